// ==== core/mhrf_map.svh ====
// Purpose: Byte codes, field limits and sizes of the message header framer
// Assumes: Included by the package and the design modules
// Notes:   Definitions only
`ifndef MHRF_MAP_SVH
`define MHRF_MAP_SVH

// Escape byte in binary mode
`define MHRF_DLE 8'h10
// Frame identification bytes
`define MHRF_FID_EXT 8'hF8
`define MHRF_FID_BASIC 8'hF9
// Station number limits
`define MHRF_STN_MAX 8'h1F
`define MHRF_STN_ALL 8'hFF
// Network number limits
`define MHRF_NET_LOCAL 8'h00
`define MHRF_NET_MAX 8'hEF
`define MHRF_NET_VIA 8'hFE
// Controller number for local or multidrop target
`define MHRF_PC_LOCAL 8'hFF
// Count bytes added by frame id, station, network, controller
`define MHRF_CNT_FIXED 16'h0004
// Byte count width on the link
`define MHRF_CNT_W 16
// ASCII hex digit codes
`define MHRF_CH_0 8'h30
`define MHRF_CH_9 8'h39
`define MHRF_CH_A 8'h41
`define MHRF_CH_F 8'h46
`define MHRF_CH_A_OFS 4'hA

`endif

// ==== core/mhrf_pkg.sv ====
// Purpose: Types and helpers shared by the header framer modules
// Assumes: mhrf_map.svh holds every number
// Notes:   Field order follows the header on the link
`default_nettype none
`include "mhrf_map.svh"

package mhrf_pkg;

    // Header field being handled, Gray along the ASCII path
    typedef enum logic [2:0] {
        F_IDLE = 3'b000,
        F_BLK = 3'b001,
        F_FID = 3'b011,
        F_STN = 3'b010,
        F_NET = 3'b110,
        F_PC = 3'b111,
        F_CNT = 3'b100
    } mhrf_fld_e;

    // Receive side state
    typedef struct packed {
        mhrf_fld_e fld;
        logic half;
        logic esc;
        logic cidx;
        logic [3:0] hi;
    } mhrf_rx_s;

    // Transmit side state
    typedef struct packed {
        mhrf_fld_e fld;
        logic half;
        logic escd;
        logic out_v;
        logic [7:0] out_b;
        logic ext;
        logic [7:0] blk;
        logic [7:0] stn;
        logic [7:0] net;
        logic [7:0] pc;
        logic [15:0] cnt;
    } mhrf_tx_s;

    // Field that follows a given one
    function automatic mhrf_fld_e mhrf_next(input mhrf_fld_e f);
        case (f)
            F_BLK: mhrf_next = F_FID;
            F_CNT: mhrf_next = F_FID;
            F_FID: mhrf_next = F_STN;
            F_STN: mhrf_next = F_NET;
            F_NET: mhrf_next = F_PC;
            default: mhrf_next = F_IDLE;
        endcase
    endfunction : mhrf_next

    // Nibble to upper-case ASCII hex digit
    function automatic logic [7:0] mhrf_nib2asc(input logic [3:0] v);
        if (v < `MHRF_CH_A_OFS) begin
            mhrf_nib2asc = `MHRF_CH_0 + {4'h0, v};
        end else begin
            mhrf_nib2asc = `MHRF_CH_A + {4'h0, v - `MHRF_CH_A_OFS};
        end
    endfunction : mhrf_nib2asc

endpackage : mhrf_pkg
`default_nettype wire

// ==== core/mhrf_hexdec.sv ====
// Purpose: ASCII hex digit decoder for received header characters
// Assumes: Digits 0-9 and upper-case A-F only
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "mhrf_map.svh"

module mhrf_hexdec (
    input wire logic [7:0] ch, // Received character
    output logic [3:0] nib, // Decoded nibble
    output logic ok // Character is a hex digit
);

    // Map digit ranges onto nibble values
    always_comb begin
        nib = 4'h0;
        ok = 1'b0;
        if (ch >= `MHRF_CH_0 && ch <= `MHRF_CH_9) begin
            nib = 4'(ch - `MHRF_CH_0);
            ok = 1'b1;
        end else if (ch >= `MHRF_CH_A && ch <= `MHRF_CH_F) begin
            nib = 4'(ch - `MHRF_CH_A) + `MHRF_CH_A_OFS;
            ok = 1'b1;
        end
    end

endmodule : mhrf_hexdec
`default_nettype wire

// ==== core/mhrf_framer.sv ====
// Purpose: Parse and build message header route fields on the serial link
// Assumes: Bytes arrive and leave on clk; strap pins are asynchronous
// Notes:   Control codes, command, data and sum check handled elsewhere
`timescale 1ns/10ps
`default_nettype none
`include "mhrf_map.svh"

module mhrf_framer
    import mhrf_pkg::*;
#(
    parameter int REST_W = 16 // Width of the remaining-length input
) (
    input wire logic clk, // 50 MHz clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic ascii_mode, // Strap: 1 ASCII, 0 binary
    input wire logic block_fmt, // Strap: ASCII header carries block no
    input wire logic [4:0] own_station, // Strap: module station number
    input wire logic rx_start, // Pulse: header begins next byte
    input wire logic rx_valid, // Received byte strobe
    input wire logic [7:0] rx_data, // Received byte
    output logic rx_done, // Pulse: header finished
    output logic rx_accept, // Header addressed here and routable
    output logic rx_drop, // Header to be discarded silently
    output logic rx_err, // Header malformed
    output logic rx_global, // Accepted header's station field was the global address
    output logic rx_ext, // Extended frame format seen
    output logic [7:0] rx_block, // Block number
    output logic [7:0] rx_station, // Station number
    output logic [7:0] rx_network, // Network number
    output logic [7:0] rx_pc, // Controller number
    input wire logic tx_start, // Pulse: build a response header
    output logic tx_start_ready, // Encoder idle, start is taken
    input wire logic tx_ext, // ASCII extended frame when set
    input wire logic [7:0] tx_block, // Block number to send
    input wire logic [7:0] tx_station, // Station number to send
    input wire logic [7:0] tx_network, // Network number to send
    input wire logic [7:0] tx_pc, // Controller number to send
    input wire logic [REST_W-1:0] tx_rest_len, // Bytes after controller
    output logic tx_valid, // Output byte valid
    input wire logic tx_ready, // Downstream takes the byte
    output logic [7:0] tx_data, // Output byte
    output logic tx_busy // Encoder still working
);

    // Count must fit the link field
    if (REST_W < 1 || REST_W > `MHRF_CNT_W) begin : g_chk
        $error("REST_W must be 1 to 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    // Whole module state
    typedef struct packed {
        logic [6:0] s1; // Strap sync stage 1
        logic [6:0] s2; // Strap sync stage 2
        logic [6:0] s3; // Strap sync stage 3
        logic [6:0] cfg; // Accepted strap value
        mhrf_rx_s rx; // Parser progress
        logic done; // Header finished pulse
        logic acc; // Accept verdict
        logic drop; // Silent discard verdict
        logic err; // Format error verdict
        logic glob; // Global address seen
        logic ext; // Extended frame seen
        logic [7:0] blk; // Parsed block number
        logic [7:0] stn; // Parsed station
        logic [7:0] net; // Parsed network
        logic [7:0] pc; // Parsed controller
        mhrf_tx_s tx; // Encoder state
    } mhrf_state_s;

    mhrf_state_s r; // Registered state
    mhrf_state_s n; // Next state

    logic ascii; // Accepted ASCII mode
    logic fmt2; // Accepted block number option
    logic [7:0] mystn; // Accepted own station
    logic [3:0] hex_nib; // Decoded received digit
    logic hex_ok; // Received byte is a digit
    logic got; // A whole field byte assembled
    logic [7:0] gb; // The assembled field byte
    logic bad; // Received byte breaks the format
    logic route_ok; // Network and controller routable
    logic addr; // Station names this module
    logic adv; // Output slot free for next byte
    logic [7:0] fb; // Field byte being sent
    logic last; // Last character of this field

    assign ascii = r.cfg[6];
    assign fmt2 = r.cfg[5];
    assign mystn = {3'h0, r.cfg[4:0]};

    // Digit decode of the received character
    mhrf_hexdec u_hex (
        .ch(rx_data),
        .nib(hex_nib),
        .ok(hex_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Strap sync, header parse, header build
    always_comb begin
        n = r;
        n.done = 1'b0;
        got = 1'b0;
        gb = 8'h00;
        bad = 1'b0;
        route_ok = 1'b0;
        addr = 1'b0;
        fb = 8'h00;
        last = 1'b0;
        adv = !r.tx.out_v || tx_ready;

        // Straps: accept once stages two and three agree
        n.s1 = {ascii_mode, block_fmt, own_station};
        n.s2 = r.s1;
        n.s3 = r.s2;
        if (r.s2 == r.s3) begin
            n.cfg = r.s3;
        end

        // Receive: assemble one field byte per step
        if (rx_start) begin
            if (ascii) begin
                n.rx.fld = fmt2 ? F_BLK : F_FID;
            end else begin
                n.rx.fld = F_CNT;
            end
            n.rx.half = 1'b0;
            n.rx.esc = 1'b0;
            n.rx.cidx = 1'b0;
        end else if (rx_valid && r.rx.fld != F_IDLE) begin
            if (ascii) begin
                // Two digits, high nibble first
                if (!hex_ok) begin
                    bad = 1'b1;
                end else if (!r.rx.half) begin
                    n.rx.hi = hex_nib;
                    n.rx.half = 1'b1;
                end else begin
                    got = 1'b1;
                    gb = {r.rx.hi, hex_nib};
                    n.rx.half = 1'b0;
                end
            end else if (r.rx.esc) begin
                // Second of a doubled escape byte
                n.rx.esc = 1'b0;
                if (rx_data == `MHRF_DLE) begin
                    got = 1'b1;
                    gb = `MHRF_DLE;
                end else begin
                    bad = 1'b1;
                end
            end else if (rx_data == `MHRF_DLE) begin
                n.rx.esc = 1'b1;
            end else begin
                got = 1'b1;
                gb = rx_data;
            end
        end

        // Receive: act on the completed field byte
        if (got) begin
            case (r.rx.fld)
                F_CNT: begin
                    // Value discarded, two bytes skipped
                    n.rx.cidx = 1'b1;
                    if (r.rx.cidx) begin
                        n.rx.fld = mhrf_next(r.rx.fld);
                    end
                end
                F_BLK: begin
                    // Every byte value legal, no sequence check
                    n.blk = gb;
                    n.rx.fld = mhrf_next(r.rx.fld);
                end
                F_FID: begin
                    if (gb == `MHRF_FID_EXT) begin
                        n.ext = 1'b1;
                    end else if (ascii && gb == `MHRF_FID_BASIC) begin
                        n.ext = 1'b0;
                    end else begin
                        bad = 1'b1;
                    end
                    n.rx.fld = mhrf_next(r.rx.fld);
                end
                F_STN: begin
                    n.stn = gb;
                    if (gb > `MHRF_STN_MAX && gb != `MHRF_STN_ALL) begin
                        bad = 1'b1;
                    end
                    n.rx.fld = mhrf_next(r.rx.fld);
                end
                F_NET: begin
                    n.net = gb;
                    n.rx.fld = mhrf_next(r.rx.fld);
                end
                F_PC: begin
                    n.pc = gb;
                    // Networks 240 up, save 254, are not routed
                    route_ok = (r.net <= `MHRF_NET_MAX) ||
                        (r.net == `MHRF_NET_VIA);
                    // Local controller only on network zero
                    if (gb == `MHRF_PC_LOCAL &&
                        r.net != `MHRF_NET_LOCAL) begin
                        route_ok = 1'b0;
                    end
                    addr = (r.stn == mystn) ||
                        (r.stn == `MHRF_STN_ALL);
                    n.acc = addr && route_ok;
                    n.drop = !(addr && route_ok);
                    // Global only for an accepted FF station
                    n.glob = addr && route_ok &&
                        (r.stn == `MHRF_STN_ALL);
                    n.err = 1'b0;
                    n.done = 1'b1;
                    n.rx.fld = mhrf_next(r.rx.fld);
                end
                default: begin
                    n.rx.fld = F_IDLE;
                end
            endcase
        end

        // Malformed header ends the parse at once
        if (bad) begin
            n.rx.fld = F_IDLE;
            n.rx.half = 1'b0;
            n.rx.esc = 1'b0;
            n.done = 1'b1;
            n.err = 1'b1;
            n.acc = 1'b0;
            n.drop = 1'b1;
            n.glob = 1'b0;
        end

        // Transmit: slot emptied by downstream
        if (adv) begin
            n.tx.out_v = 1'b0;
        end

        // Transmit: latch fields and work out the count
        if (tx_start && r.tx.fld == F_IDLE) begin
            n.tx.ext = tx_ext;
            n.tx.blk = tx_block;
            n.tx.stn = tx_station;
            n.tx.net = tx_network;
            n.tx.pc = tx_pc;
            n.tx.cnt = `MHRF_CNT_FIXED + 16'(tx_rest_len);
            n.tx.half = 1'b0;
            n.tx.escd = 1'b0;
            if (ascii) begin
                n.tx.fld = fmt2 ? F_BLK : F_FID;
            end else begin
                n.tx.fld = F_CNT;
            end
        end else if (adv && r.tx.fld != F_IDLE) begin
            // Pick the byte of the current field
            case (r.tx.fld)
                F_CNT: fb = r.tx.half ? r.tx.cnt[15:8] : r.tx.cnt[7:0];
                F_BLK: fb = r.tx.blk;
                F_FID: begin
                    if (ascii && !r.tx.ext) begin
                        fb = `MHRF_FID_BASIC;
                    end else begin
                        fb = `MHRF_FID_EXT;
                    end
                end
                F_STN: fb = r.tx.stn;
                F_NET: fb = r.tx.net;
                F_PC: fb = r.tx.pc;
                default: fb = 8'h00;
            endcase
            n.tx.out_v = 1'b1;
            if (ascii) begin
                // High digit first, then low digit
                if (r.tx.half) begin
                    n.tx.out_b = mhrf_nib2asc(fb[3:0]);
                end else begin
                    n.tx.out_b = mhrf_nib2asc(fb[7:4]);
                end
                last = r.tx.half;
                n.tx.half = !r.tx.half;
            end else if (fb == `MHRF_DLE && !r.tx.escd) begin
                // Insert the escape ahead of the real byte
                n.tx.out_b = `MHRF_DLE;
                n.tx.escd = 1'b1;
            end else begin
                n.tx.out_b = fb;
                n.tx.escd = 1'b0;
                if (r.tx.fld == F_CNT && !r.tx.half) begin
                    n.tx.half = 1'b1;
                end else begin
                    last = 1'b1;
                end
            end
            if (last) begin
                n.tx.half = 1'b0;
                n.tx.fld = mhrf_next(r.tx.fld);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // All state cleared on reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rx_done = r.done;
    assign rx_accept = r.acc;
    assign rx_drop = r.drop;
    assign rx_err = r.err;
    assign rx_global = r.glob;
    assign rx_ext = r.ext;
    assign rx_block = r.blk;
    assign rx_station = r.stn;
    assign rx_network = r.net;
    assign rx_pc = r.pc;
    assign tx_start_ready = (r.tx.fld == F_IDLE);
    assign tx_valid = r.tx.out_v;
    assign tx_data = r.tx.out_b;
    assign tx_busy = (r.tx.fld != F_IDLE) || r.tx.out_v;

endmodule : mhrf_framer
`default_nettype wire

// ==== testbench/mhrf_chk_asserts.sv ====
// Purpose: Port checker for the header framer
// Assumes: Bound to mhrf_framer from the bench top
// Notes:   One clock domain, async reset
`timescale 1ns/10ps
`default_nettype none
module mhrf_chk (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset, low
    input wire logic rx_done, // Parse end
    input wire logic rx_accept, // Verdict
    input wire logic rx_drop, // Verdict
    input wire logic rx_err, // Verdict
    input wire logic rx_global, // Global hit
    input wire logic [7:0] rx_station, // Field
    input wire logic [7:0] rx_network, // Field
    input wire logic [7:0] rx_pc, // Field
    input wire logic tx_start, // Start
    input wire logic tx_start_ready, // Idle
    input wire logic tx_valid, // Byte valid
    input wire logic tx_ready, // Byte taken
    input wire logic [7:0] tx_data // Byte
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    // Receive verdicts
    a_net_unroutable: assert property (
        rx_done && !rx_err && rx_network > 8'hEF && rx_network != 8'hFE
        |-> !rx_accept) else $error("unroutable network accepted");
    a_pc_local_only: assert property (
        rx_done && rx_pc == 8'hFF && rx_network != 8'h00 |-> !rx_accept)
        else $error("local controller off network zero");
    a_global_is_ff: assert property (
        rx_done && rx_global |-> rx_station == 8'hFF && rx_accept)
        else $error("global flag without FF");
    a_numbered_no_glob: assert property (
        rx_done && rx_station != 8'hFF |-> !rx_global)
        else $error("numbered station raised global");
    a_verdict_excl: assert property (
        rx_done |-> (rx_accept ^ rx_drop) && !(rx_err && rx_accept))
        else $error("verdicts clash");
    a_station_range: assert property (
        rx_done && !rx_err |-> rx_station <= 8'h1F || rx_station == 8'hFF)
        else $error("bad station passed");
    ////////////////////////////////////////////////////////////////
    // Transmit handshake
    a_tx_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte changed while pending");
    a_tx_first: assert property (
        tx_start && tx_start_ready |-> ##2 tx_valid)
        else $error("first byte late");
    // Main scenarios seen
    c_global: cover property (rx_done && rx_global);
    c_err: cover property (rx_done && rx_err);
    c_stall: cover property (tx_valid && !tx_ready ##1 tx_ready);
endmodule : mhrf_chk
`default_nettype wire

// ==== testbench/mhrf_host.sv ====
// Purpose: Host model: sends command headers, takes responses
// Assumes: Bench calls send and sets slow
// Notes:   Slow mode gaps bytes and stalls every other cycle
`timescale 1ns/10ps
`default_nettype none
module mhrf_host (
    input wire logic clk, // Clock
    output logic rx_start, // Header start
    output logic rx_valid, // Byte strobe
    output logic [7:0] rx_data, // Byte
    input wire logic tx_valid, // Byte valid
    input wire logic [7:0] tx_data, // Byte
    output logic tx_ready // Byte taken
);
    logic slow; // Gaps and stalls
    logic [7:0] got[$]; // Bytes taken
    initial begin
        slow = 1'b0;
        rx_start = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h5A;
        tx_ready = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // Send one header, doubling 10H bytes when esc is set
    task automatic send(input logic [7:0] b[$], input logic esc);
        @(posedge clk);
        rx_start <= 1'b1;
        @(posedge clk);
        rx_start <= 1'b0;
        foreach (b[i]) begin
            repeat ((esc && b[i] == 8'h10) ? 2 : 1) begin
                if (slow) begin
                    rx_valid <= 1'b0;
                    rx_data <= ~rx_data;
                    @(posedge clk);
                end
                rx_valid <= 1'b1;
                rx_data <= b[i];
                @(posedge clk);
            end
        end
        rx_valid <= 1'b0;
        rx_data <= ~b[b.size()-1];
    endtask : send
    // Sink: takes bytes, stalls in slow mode
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule : mhrf_host
`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the header framer
// Assumes: Host model on the link side
// Notes:   Each scenario is a task
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
    check_count++; \
    if ((a) !== (e)) begin \
        fail_count++; \
        $display("mismatch at %0t got %0h exp %0h", $time, a, e); \
    end \
end
module testbench;
    typedef logic [7:0] mhrf_tb_q_t[$]; // Byte list
    logic clk, reset_n, ascii_mode, block_fmt, rx_start, rx_valid;
    logic [4:0] own_station;
    logic [7:0] rx_data, rx_block, rx_station, rx_network, rx_pc;
    logic rx_done, rx_accept, rx_drop, rx_err, rx_global, rx_ext;
    logic tx_start, tx_start_ready, tx_ext, tx_valid, tx_ready, tx_busy;
    logic [7:0] tx_block, tx_station, tx_network, tx_pc, tx_data;
    logic [15:0] tx_rest_len;
    int fail_count, check_count, cycles, dones;
    mhrf_framer u_mhrf_framer (.clk, .reset_n, .ascii_mode, .block_fmt,
        .own_station, .rx_start, .rx_valid, .rx_data, .rx_done, .rx_accept,
        .rx_drop, .rx_err, .rx_global, .rx_ext, .rx_block, .rx_station,
        .rx_network, .rx_pc, .tx_start, .tx_start_ready, .tx_ext,
        .tx_block, .tx_station, .tx_network, .tx_pc, .tx_rest_len,
        .tx_valid, .tx_ready, .tx_data, .tx_busy);
    mhrf_host u_mhrf_host (.clk, .rx_start, .rx_valid, .rx_data,
        .tx_valid, .tx_data, .tx_ready);
    // Clock, 20 ns
    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    // Helpers
    function automatic mhrf_tb_q_t s2q(input string s);
        mhrf_tb_q_t q;
        foreach (s[i]) q.push_back(s[i]);
        return q;
    endfunction : s2q
    task automatic straps(input logic a, input logic b, input logic [4:0] s);
        ascii_mode <= a;
        block_fmt <= b;
        own_station <= s;
        repeat (6) @(posedge clk);
    endtask : straps
    // Send a header, expect {accept, drop, err, global}
    task automatic rx_chk(input mhrf_tb_q_t b, input logic e,
                          input logic [3:0] exp);
        int n, d0;
        d0 = dones;
        u_mhrf_host.send(b, e);
        #1;
        for (n = 0; n < 20 && rx_done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK({rx_accept, rx_drop, rx_err, rx_global}, exp)
        @(posedge clk);
        `CHK(dones, d0 + 1)
    endtask : rx_chk
    // Build a response header, compare the bytes sent
    task automatic tx_run(input logic [7:0] f[4], input logic ext,
                          input logic [15:0] rest, input mhrf_tb_q_t e);
        int n;
        for (n = 0; n < 50 && tx_start_ready !== 1'b1; n++) begin
            @(posedge clk);
        end
        {tx_block, tx_station, tx_network, tx_pc} <= {f[0], f[1], f[2], f[3]};
        tx_ext <= ext;
        tx_rest_len <= rest;
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        repeat (2) @(posedge clk);
        tx_start <= 1'b1; // Refused while busy
        @(posedge clk);
        tx_start <= 1'b0;
        for (n = 0; n < 200 && u_mhrf_host.got.size() < e.size(); n++) begin
            @(posedge clk);
        end
        repeat (20) @(posedge clk);
        `CHK(u_mhrf_host.got.size(), e.size())
        foreach (e[i]) `CHK(u_mhrf_host.got[i], e[i])
        `CHK({tx_busy, tx_start_ready}, 2'h1)
        u_mhrf_host.got.delete();
    endtask : tx_run
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_bin_rx;
        straps(1'b0, 1'b0, 5'h03);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h03, 8'h00, 8'hFF}, 1, 4'h8);
        `CHK({rx_station, rx_network, rx_pc}, 24'h0300FF)
        rx_chk('{8'h12, 8'h34, 8'hF8, 8'hFF, 8'hFE, 8'h05}, 1, 4'h9);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'hFF, 8'hF0, 8'h01}, 1, 4'h4);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h04, 8'h00, 8'hFF}, 1, 4'h4);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h03, 8'hEF, 8'h40}, 1, 4'h8);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h03, 8'h00, 8'hFF, 8'h00},
            1, 4'h8);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h03, 8'hF0, 8'h01}, 1, 4'h4);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h03, 8'hFF, 8'h7D}, 1, 4'h4);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h03, 8'h01, 8'hFF}, 1, 4'h4);
        rx_chk('{8'h00, 8'h00, 8'hF9, 8'h03, 8'h00, 8'hFF}, 1, 4'h6);
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h20, 8'h00, 8'hFF}, 1, 4'h6);
        $display("test bin_rx done");
    endtask : t_bin_rx
    task automatic t_esc_rx;
        straps(1'b0, 1'b0, 5'h10);
        u_mhrf_host.slow = 1'b1;
        rx_chk('{8'h10, 8'h00, 8'hF8, 8'h10, 8'h00, 8'hFF}, 1, 4'h8);
        `CHK(rx_station, 8'h10)
        rx_chk('{8'h00, 8'h00, 8'hF8, 8'h10, 8'h03, 8'h00}, 0, 4'h6);
        u_mhrf_host.slow = 1'b0;
        $display("test esc_rx done");
    endtask : t_esc_rx
    task automatic t_asc_rx;
        straps(1'b1, 1'b1, 5'h0A);
        rx_chk(s2q("A5F80A00FF"), 0, 4'h8);
        `CHK({rx_block, rx_station, rx_ext}, {8'hA5, 8'h0A, 1'h1})
        rx_chk(s2q("FFF9FF00FF"), 0, 4'h9);
        `CHK({rx_block, rx_ext}, 9'h1FE)
        rx_chk(s2q("00F70A00FF"), 0, 4'h6);
        rx_chk(s2q("00F80G00FF"), 0, 4'h6);
        straps(1'b1, 1'b0, 5'h0A);
        rx_chk(s2q("F80A00FF"), 0, 4'h8);
        $display("test asc_rx done");
    endtask : t_asc_rx
    task automatic t_tx;
        straps(1'b0, 1'b0, 5'h03);
        u_mhrf_host.slow = 1'b1;
        tx_run('{8'h00, 8'h01, 8'h00, 8'hFF}, 0, 16'h0FFC,
            '{8'h00, 8'h10, 8'h10, 8'hF8, 8'h01, 8'h00, 8'hFF});
        u_mhrf_host.slow = 1'b0;
        straps(1'b1, 1'b1, 5'h03);
        tx_run('{8'h3C, 8'h1F, 8'h00, 8'hFF}, 0, 16'h0000,
            s2q("3CF91F00FF"));
        tx_run('{8'h00, 8'h0A, 8'hEF, 8'h40}, 1, 16'h0000,
            s2q("00F80AEF40"));
        $display("test tx done");
    endtask : t_tx
    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end
    // Parse ends seen, sampled mid-cycle
    always @(negedge clk) begin
        if (rx_done === 1'b1) begin
            dones++;
        end
    end
    // Main sequence
    initial begin
        {clk, reset_n, ascii_mode, block_fmt} = '0;
        {own_station, tx_start, tx_ext, tx_rest_len} = '0;
        {tx_block, tx_station, tx_network, tx_pc} = '0;
        {fail_count, check_count, cycles, dones} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_bin_rx();
        t_esc_rx();
        t_asc_rx();
        t_tx();
        results();
    end
endmodule : testbench
bind mhrf_framer mhrf_chk u_mhrf_chk (.clk, .reset_n, .rx_done,
    .rx_accept, .rx_drop, .rx_err, .rx_global, .rx_station, .rx_network,
    .rx_pc, .tx_start, .tx_start_ready, .tx_valid, .tx_ready, .tx_data);
`default_nettype wire
